// [rtl/drt_map.svh]
// drt_map.svh: offsets, fields, reset values and timing counts
// assumes a 40 MHz pclk and eight node slots
`ifndef DRT_MAP_SVH
`define DRT_MAP_SVH
`define DRT_N 8
`define DRT_CLK_NS 25
`define DRT_MS_NS 1000000
`define DRT_MS_CYC (`DRT_MS_NS / `DRT_CLK_NS)
`define DRT_PER_MIN_MS 16'd500
`define DRT_PER_MAX_MS 16'd30000
`define DRT_RETRY_MS 16'd100
`define DRT_ATTEMPTS 2'd3
`define DRT_ACK_A 2'b00
`define DRT_ACK_B 2'b10
`define DRT_A_CTRL 8'h00
`define DRT_A_STAT 8'h04
`define DRT_A_PER 8'h08
`define DRT_A_DLN 8'h0c
`define DRT_A_TIDX 8'h10
`define DRT_A_TDAT 8'h14
`define DRT_A_VIS 8'h18
`define DRT_A_CAP 8'h1c
`define DRT_CTRL_RST 11'h000
`define DRT_PER_RST 16'd1000
`define DRT_DLN_RST 16'd50
`define DRT_F_ISCTRL 0
`define DRT_F_ISBKP 1
`define DRT_F_REQDIST 2
`define DRT_F_OWNCAP 3
`endif

// [rtl/drt_pkg.sv]
// drt_pkg: types shared by the routing and topology manager
// assumes drt_map.svh carries all numeric constants
package drt_pkg;
   typedef enum logic [1:0] {
      DRT_RS_IDLE = 2'b00,
      DRT_RS_WAIT = 2'b01,
      DRT_RS_QUIT = 2'b11
   } drt_rpt_state_type;
   typedef logic [7:0] drt_seq_type;
endpackage

// [rtl/drt_top.sv]
// drt_top: routing/topology manager for controller, backup and node roles
// assumes message parsing/building outside, all event inputs on pclk
//
// Functional notes
// - central mode: nodes report, controller computes and sends table, nodes use it
// - distributed mode: node computes own table with advertised algorithm
// - controller advertises mode in plan; nodes follow advertised mode
// - node reports its distributed capability at registration and in reports
// - controller forces central mode if any admitted node lacks capability
// - controller and backup store topology from reports and query replies
// - node reports at topology interval and on topology changes
// - query names wanted fields; reply carries exactly those fields
// - distributed mode: backup keeps full topology map from reports
// - central mode: visibility changes forwarded to backup by sync message
// - central mode: reports, joins, leaves, losses update controller topology
// - routing update sent within deadline after topology update; changes merge
// - full-topology update repeats with period between 0.5 and 30 s
// - first report of new node triggers full update; proxy becomes relay
// - route change: new unicast and broadcast tables sent to all
// - plan carries sequence number of last sent routing update
// - node seeing newer plan sequence sends resend request
// - plan sequence older than received one: node stays synced, no request
// - update acknowledges reports with ack type 00 or 10 and their sequence
// - resend request answered by reply with independent sequence
// - controller keeps N by N next-hop table, zero means direct
// - unacked report retried 100 ms apart; after three, self-resign
`include "drt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module drt_top
   import drt_pkg::*;
#(
   parameter int unsigned MS_CYCLES = `DRT_MS_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rpt_rx_valid,
   input wire logic rpt_rx_reply,
   input wire logic [2:0] rpt_rx_node,
   input wire logic [7:0] rpt_rx_seq,
   input wire logic [1:0] rpt_rx_ack,
   input wire logic rpt_rx_first,
   input wire logic rpt_rx_cap,
   input wire logic [7:0] rpt_rx_vis,
   input wire logic rpt_rx_proxy_valid,
   input wire logic [2:0] rpt_rx_proxy,
   input wire logic node_join,
   input wire logic node_leave,
   input wire logic node_lost,
   input wire logic [2:0] evt_node,
   input wire logic map_rx_valid,
   input wire logic map_rx_dist,
   input wire logic [7:0] map_rx_seq,
   input wire logic [3:0] map_rx_algo,
   input wire logic [15:0] map_rx_interval,
   input wire logic rupd_rx_valid,
   input wire logic [7:0] rupd_rx_seq,
   input wire logic rupd_rx_ack,
   input wire logic qry_rx_valid,
   input wire logic [7:0] qry_rx_fields,
   input wire logic rsq_rx_valid,
   input wire logic topo_change,
   input wire logic tbl_ld_valid,
   input wire logic [5:0] tbl_ld_idx,
   input wire logic [7:0] tbl_ld_hop,
   input wire logic [2:0] lookup_dst,
   output logic [7:0] next_hop,
   output logic map_dist,
   output logic [7:0] map_seq,
   output logic [3:0] map_algo,
   output logic rupd_tx,
   output logic [7:0] rupd_seq,
   output logic rupd_full,
   output logic rupd_tables,
   output logic [7:0] rupd_ack,
   output logic [7:0] rupd_relay,
   output logic route_calc,
   output logic bsync_tx,
   output logic [2:0] bsync_node,
   output logic [7:0] bsync_diff,
   output logic rsr_tx,
   output logic [7:0] rsr_seq,
   output logic rsq_tx,
   output logic qrep_tx,
   output logic [7:0] qrep_fields,
   output logic rpt_tx,
   output logic [1:0] rpt_rep,
   output logic rpt_cap,
   output logic resign
);
   localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

   // modulo-256 ordering: a is ahead of b within half the space
   function automatic logic seq_newer(input drt_seq_type a, input drt_seq_type b);
      logic [7:0] d;
      d = a - b;
      return (d != 8'h00) && !d[7];
   endfunction

   function automatic logic at(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   logic [10:0] ctrl_q;
   logic [15:0] per_q, dln_q;
   logic [5:0] tidx_q;
   logic [7:0] rt_q [0:63];
   logic [7:0] vis_q [0:7];
   logic [7:0] ackseq_q [0:7];
   logic [7:0] cap_q, admit_q, ack_q, relay_q, last_rx_q;
   logic [15:0] pre_q, dl_ms_q, per_ms_q, iv_ms_q, wait_ms_q, iv_q;
   logic pend_q, full_q, dirty_q, seen_q, synced_q, mode_q, rdy_q, err_q;
   logic [31:0] rd_q;
   logic [1:0] att_q;
   drt_rpt_state_type rs_q, rs_d;

   // bus decode
   wire setup = psel & ~penable;
   wire s_ctrl = at(paddr, `DRT_A_CTRL);
   wire s_per = at(paddr, `DRT_A_PER);
   wire s_dln = at(paddr, `DRT_A_DLN);
   wire s_tidx = at(paddr, `DRT_A_TIDX);
   wire s_tdat = at(paddr, `DRT_A_TDAT);
   wire a_ok = s_ctrl | s_per | s_dln | s_tidx | s_tdat | at(paddr, `DRT_A_STAT)
               | at(paddr, `DRT_A_VIS) | at(paddr, `DRT_A_CAP);
   wire wr = psel & penable & pwrite & rdy_q;
   wire is_ctrl = ctrl_q[`DRT_F_ISCTRL];
   wire is_bkp = ctrl_q[`DRT_F_ISBKP];
   wire [2:0] own = ctrl_q[10:8];
   wire [31:0] stat = {8'h00, 1'b0, rs_q, pend_q, att_q, synced_q, mode_q,
                       last_rx_q, rupd_seq};
   wire [31:0] rd_mux = s_ctrl ? {21'h0, ctrl_q} : s_per ? {16'h0, per_q} :
                        s_dln ? {16'h0, dln_q} : s_tidx ? {26'h0, tidx_q} :
                        s_tdat ? {24'h0, rt_q[tidx_q]} :
                        at(paddr, `DRT_A_VIS) ? {16'h0, ackseq_q[tidx_q[5:3]],
                        vis_q[tidx_q[5:3]]} :
                        at(paddr, `DRT_A_CAP) ? {16'h0, admit_q, cap_q} : stat;

   // no wait state: answer latched in setup, shown in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         rd_q <= 32'h0000_0000;
      end else begin
         rdy_q <= setup;
         err_q <= setup & ~a_ok;
         rd_q <= (setup & ~pwrite & a_ok) ? rd_mux : 32'h0000_0000;
      end
   end
   assign pready = rdy_q;
   assign pslverr = err_q;
   assign prdata = rd_q;

   // software registers; deadline kept at one ms or more
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `DRT_CTRL_RST;
         per_q <= `DRT_PER_RST;
         dln_q <= `DRT_DLN_RST;
         tidx_q <= 6'h00;
      end else if (wr) begin
         if (s_ctrl) ctrl_q <= pwdata[10:0];
         if (s_per) per_q <= pwdata[15:0];
         if (s_dln) dln_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
         if (s_tidx) tidx_q <= pwdata[5:0];
      end
   end

   // next-hop table, data only so no reset; zero entry means direct link
   wire tbl_sw = wr & s_tdat;
   always_ff @(posedge pclk) begin
      if (tbl_sw) rt_q[tidx_q] <= pwdata[7:0];
      else if (tbl_ld_valid) rt_q[tbl_ld_idx] <= tbl_ld_hop;
   end

   // millisecond tick shared by every timer
   wire ms = (pre_q == MS_LAST);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pre_q <= 16'h0000;
      else pre_q <= ms ? 16'h0000 : pre_q + 16'h0001;
   end

   // controller event decode
   wire central = ~mode_q;
   wire keep = is_ctrl | is_bkp;
   wire rpt_ind = rpt_rx_valid & ~rpt_rx_reply;
   wire ev_topo = is_ctrl & central & (rpt_ind | node_join | node_leave | node_lost);
   wire ev_ack = is_ctrl & central & rpt_ind
                 & (rpt_rx_ack == `DRT_ACK_A | rpt_rx_ack == `DRT_ACK_B);
   wire ev_first = is_ctrl & central & rpt_ind & rpt_rx_first;
   wire all_cap = &(cap_q | ~admit_q);
   wire vis_chg = vis_q[rpt_rx_node] != rpt_rx_vis;
   wire [15:0] per_lim = (per_q < `DRT_PER_MIN_MS) ? `DRT_PER_MIN_MS :
                         (per_q >= `DRT_PER_MAX_MS) ? `DRT_PER_MAX_MS - 16'd1 : per_q;
   wire per_due = is_ctrl & central & ms & (per_ms_q >= per_lim);
   wire dl_due = is_ctrl & pend_q & ms & (dl_ms_q >= dln_q - 16'd1);
   wire send = per_due | dl_due;

   // topology store, capability and admission per node slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_q <= 8'h00;
         admit_q <= 8'h00;
         for (int i = 0; i < `DRT_N; i++) vis_q[i] <= 8'h00;
      end else begin
         if (keep & rpt_rx_valid) begin
            vis_q[rpt_rx_node] <= rpt_rx_vis;
            cap_q[rpt_rx_node] <= rpt_rx_cap;
         end
         if (is_ctrl & node_join) admit_q[evt_node] <= 1'b1;
         else if (is_ctrl & (node_leave | node_lost)) admit_q[evt_node] <= 1'b0;
      end
   end

   // acknowledge and relay bits: a new set beats the clear of a send
   generate
      for (genvar g = 0; g < `DRT_N; g++) begin : g_node
         wire set_a = ev_ack & (rpt_rx_node == 3'(g));
         wire set_r = ev_first & rpt_rx_proxy_valid & (rpt_rx_proxy == 3'(g));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ack_q[g] <= 1'b0;
               relay_q[g] <= 1'b0;
               ackseq_q[g] <= 8'h00;
            end else begin
               ack_q[g] <= set_a | (ack_q[g] & ~send);
               relay_q[g] <= set_r | (relay_q[g] & ~send);
               if (set_a) ackseq_q[g] <= rpt_rx_seq;
            end
         end
      end
   endgenerate

   // update scheduling: changes merge until the deadline expires
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
         full_q <= 1'b0;
         dirty_q <= 1'b0;
         dl_ms_q <= 16'h0000;
         per_ms_q <= 16'h0000;
      end else begin
         pend_q <= ev_topo | ev_first | (pend_q & ~send);
         full_q <= ev_first | (full_q & ~send);
         dirty_q <= (is_ctrl & (tbl_sw | tbl_ld_valid)) | (dirty_q & ~send);
         dl_ms_q <= (~pend_q | send) ? 16'h0000 : dl_ms_q + {15'h0, ms};
         per_ms_q <= send ? 16'h0000 : per_ms_q + {15'h0, ms};
      end
   end

   // controller outputs: updates, plan fields, backup sync, resend replies
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rupd_tx <= 1'b0;
         rupd_seq <= 8'h00;
         rupd_full <= 1'b0;
         rupd_tables <= 1'b0;
         rupd_ack <= 8'h00;
         rupd_relay <= 8'h00;
         route_calc <= 1'b0;
         bsync_tx <= 1'b0;
         bsync_node <= 3'h0;
         bsync_diff <= 8'h00;
         rsr_tx <= 1'b0;
         rsr_seq <= 8'h00;
         map_seq <= 8'h00;
      end else begin
         rupd_tx <= send;
         route_calc <= ev_topo;
         rsr_tx <= is_ctrl & rsq_rx_valid;
         bsync_tx <= is_ctrl & central & rpt_ind & vis_chg;
         if (is_ctrl & rsq_rx_valid) rsr_seq <= rsr_seq + 8'h01;
         if (is_ctrl & central & rpt_ind & vis_chg) begin
            bsync_node <= rpt_rx_node;
            bsync_diff <= vis_q[rpt_rx_node] ^ rpt_rx_vis;
         end
         if (send) begin
            rupd_seq <= rupd_seq + 8'h01;
            map_seq <= rupd_seq + 8'h01;
            rupd_full <= per_due | full_q;
            rupd_tables <= dirty_q;
            rupd_ack <= ack_q;
            rupd_relay <= relay_q;
         end
      end
   end

   // mode: controller derives it, any other role follows the plan
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 1'b0;
         map_algo <= 4'h0;
      end else if (is_ctrl) begin
         mode_q <= ctrl_q[`DRT_F_REQDIST] & all_cap;
      end else if (map_rx_valid) begin
         mode_q <= map_rx_dist;
         map_algo <= map_rx_algo;
      end
   end
   assign map_dist = mode_q;

   // node: plan sequence check and update tracking
   wire map_new = seq_newer(map_rx_seq, last_rx_q);
   wire upd_new = ~seen_q | seq_newer(rupd_rx_seq, last_rx_q);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsq_tx <= 1'b0;
         synced_q <= 1'b1;
         seen_q <= 1'b0;
         last_rx_q <= 8'h00;
      end else begin
         rsq_tx <= ~is_ctrl & map_rx_valid & map_new;
         if (~is_ctrl & map_rx_valid) synced_q <= ~map_new;
         if (~is_ctrl & rupd_rx_valid & upd_new) begin
            last_rx_q <= rupd_rx_seq;
            seen_q <= 1'b1;
         end
      end
   end

   // query reply echoes exactly the requested field mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qrep_tx <= 1'b0;
         qrep_fields <= 8'h00;
         next_hop <= 8'h00;
      end else begin
         qrep_tx <= ~is_ctrl & qry_rx_valid;
         if (qry_rx_valid) qrep_fields <= qry_rx_fields;
         next_hop <= rt_q[{own, lookup_dst}];
      end
   end

   // periodic report timer from plan interval, zero stops it
   wire iv_due = ms & (iv_q != 16'h0000) & (iv_ms_q >= iv_q - 16'd1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iv_q <= 16'h0000;
         iv_ms_q <= 16'h0000;
      end else begin
         if (~is_ctrl & map_rx_valid) iv_q <= map_rx_interval;
         iv_ms_q <= (iv_due | iv_q == 16'h0000) ? 16'h0000 : iv_ms_q + {15'h0, ms};
      end
   end

   // report retry machine; a change during a wait rides on the retry
   wire trig = ~is_ctrl & (topo_change | iv_due | node_join);
   wire acked = rupd_rx_valid & rupd_rx_ack;
   wire retry = ms & (wait_ms_q >= `DRT_RETRY_MS);
   always_comb begin
      rs_d = rs_q;
      case (rs_q)
         DRT_RS_IDLE: if (trig) rs_d = DRT_RS_WAIT;
         DRT_RS_WAIT: begin
            if (acked) rs_d = DRT_RS_IDLE;
            else if (retry & att_q == `DRT_ATTEMPTS) rs_d = DRT_RS_QUIT;
         end
         DRT_RS_QUIT: rs_d = DRT_RS_IDLE;
         default: rs_d = DRT_RS_IDLE;
      endcase
   end
   wire fire = (rs_q == DRT_RS_IDLE & trig)
               | (rs_q == DRT_RS_WAIT & ~acked & retry & att_q != `DRT_ATTEMPTS);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rs_q <= DRT_RS_IDLE;
         att_q <= 2'd0;
         wait_ms_q <= 16'h0000;
         rpt_tx <= 1'b0;
         rpt_rep <= 2'd0;
         rpt_cap <= 1'b0;
         resign <= 1'b0;
      end else begin
         rs_q <= rs_d;
         rpt_tx <= fire;
         rpt_cap <= ctrl_q[`DRT_F_OWNCAP];
         resign <= (rs_d == DRT_RS_QUIT);
         wait_ms_q <= fire ? 16'h0000 : wait_ms_q + {15'h0, ms};
         if (fire) begin
            att_q <= (rs_q == DRT_RS_IDLE) ? 2'd1 : att_q + 2'd1;
            rpt_rep <= (rs_q == DRT_RS_IDLE) ? 2'd1 : att_q + 2'd1;
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_CENTRAL_FORCED: assert property (
      is_ctrl && |(admit_q & ~cap_q) |=> !map_dist)
      else $error("distributed mode with an incapable node");
   AST_MODE_FOLLOWS: assert property (
      !is_ctrl && map_rx_valid |=> map_dist == $past(map_rx_dist))
      else $error("node mode does not follow plan");
   AST_PLAN_SEQ: assert property (
      rupd_tx |-> map_seq == rupd_seq && rupd_seq == $past(rupd_seq) + 8'h01)
      else $error("plan sequence not last update");
   AST_RESEND_REQ: assert property (
      !is_ctrl && map_rx_valid && seq_newer(map_rx_seq, last_rx_q) |=> rsq_tx)
      else $error("missed update not requested");
   AST_STALE_PLAN: assert property (
      !is_ctrl && map_rx_valid && !seq_newer(map_rx_seq, last_rx_q) |=> !rsq_tx && synced_q)
      else $error("stale plan caused a request");
   AST_RESEND_REPLY: assert property (
      is_ctrl && rsq_rx_valid |=> rsr_tx && rsr_seq == $past(rsr_seq) + 8'h01)
      else $error("resend request not answered");
   AST_QUERY_FIELDS: assert property (
      !is_ctrl && qry_rx_valid |=> qrep_tx && qrep_fields == $past(qry_rx_fields))
      else $error("query reply fields differ");
   AST_ACK_HELD: assert property (
      ev_ack |=> ack_q[$past(rpt_rx_node)] && ackseq_q[$past(rpt_rx_node)] == $past(rpt_rx_seq))
      else $error("report acknowledgement lost");
   AST_DEADLINE: assert property (
      pend_q && is_ctrl |-> dl_ms_q < dln_q)
      else $error("update deadline overrun");
   AST_RETRY_LIMIT: assert property (
      rpt_tx |-> rpt_rep >= 2'd1 && rpt_rep <= `DRT_ATTEMPTS ##1 !rpt_tx)
      else $error("report repetition out of range");

   COV_UPDATE: cover property (ev_topo ##[1:300] rupd_tx);
   COV_RESIGN: cover property (resign);
   COV_RESEND: cover property (map_rx_valid ##1 rsq_tx);
endmodule
`default_nettype wire

// [test/drt_peer.sv]
// drt_peer: far nodes and remote controller, as messages reaching the block
// assumes calls come just after a rising pclk edge
`timescale 1ns/1ps
`default_nettype none
module drt_peer (
   input wire logic pclk,
   output logic rpt_rx_valid,
   output logic rpt_rx_reply,
   output logic [2:0] rpt_rx_node,
   output logic [7:0] rpt_rx_seq,
   output logic [1:0] rpt_rx_ack,
   output logic rpt_rx_first,
   output logic rpt_rx_cap,
   output logic [7:0] rpt_rx_vis,
   output logic rpt_rx_proxy_valid,
   output logic [2:0] rpt_rx_proxy,
   output logic map_rx_valid,
   output logic map_rx_dist,
   output logic [7:0] map_rx_seq,
   output logic [3:0] map_rx_algo,
   output logic [15:0] map_rx_interval,
   output logic rupd_rx_valid,
   output logic [7:0] rupd_rx_seq,
   output logic rupd_rx_ack,
   output logic qry_rx_valid,
   output logic [7:0] qry_rx_fields,
   output logic rsq_rx_valid
);
   initial begin
      {rpt_rx_valid, rpt_rx_reply, rpt_rx_node, rpt_rx_seq, rpt_rx_ack, rpt_rx_first,
         rpt_rx_cap, rpt_rx_vis, rpt_rx_proxy_valid, rpt_rx_proxy} = '0;
      {map_rx_valid, map_rx_dist, map_rx_seq, map_rx_algo, map_rx_interval} = '0;
      {rupd_rx_valid, rupd_rx_seq, rupd_rx_ack, qry_rx_valid, qry_rx_fields} = '0;
      rsq_rx_valid = 1'b0;
   end
   // fields go stale after the pulse, so they flip rather than hold
   task settle;
      @(posedge pclk);
      {rpt_rx_valid, map_rx_valid, rupd_rx_valid, qry_rx_valid, rsq_rx_valid} <= '0;
      {rpt_rx_seq, rpt_rx_vis, map_rx_seq, rupd_rx_seq, qry_rx_fields}
         <= ~{rpt_rx_seq, rpt_rx_vis, map_rx_seq, rupd_rx_seq, qry_rx_fields};
   endtask
   // topology report of a remote node
   task report(input logic [2:0] n, input logic [7:0] s, input logic [1:0] a,
      input logic fi, input logic [7:0] v, input logic pv);
      @(posedge pclk);
      rpt_rx_valid <= 1'b1;
      rpt_rx_reply <= 1'b0;
      rpt_rx_node <= n;
      rpt_rx_seq <= s;
      rpt_rx_ack <= a;
      rpt_rx_first <= fi;
      rpt_rx_cap <= 1'b1;
      rpt_rx_vis <= v;
      rpt_rx_proxy_valid <= pv;
      rpt_rx_proxy <= 3'd2;
      settle();
   endtask
   // medium access plan from the controller, central mode advertised
   task map(input logic [7:0] s);
      @(posedge pclk);
      map_rx_valid <= 1'b1;
      map_rx_dist <= 1'b0;
      map_rx_seq <= s;
      map_rx_algo <= 4'h1;
      map_rx_interval <= 16'h0;
      settle();
   endtask
   task upd(input logic [7:0] s, input logic a);
      @(posedge pclk);
      rupd_rx_valid <= 1'b1;
      rupd_rx_seq <= s;
      rupd_rx_ack <= a;
      settle();
   endtask
   task query(input logic [7:0] f);
      @(posedge pclk);
      qry_rx_valid <= 1'b1;
      qry_rx_fields <= f;
      settle();
   endtask
   task resend;
      @(posedge pclk);
      rsq_rx_valid <= 1'b1;
      settle();
   endtask
endmodule
`default_nettype wire

// [test/tb.sv]
// tb: drives the manager over APB and event ports, checks outputs from a queue
// assumes drt_peer for remote traffic; 4 cycles stand in for 1 ms
`include "drt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, rpt_rx_seq, rpt_rx_vis, map_rx_seq, rupd_rx_seq, qry_rx_fields;
   logic [31:0] pwdata, prdata;
   logic rpt_rx_valid, rpt_rx_reply, rpt_rx_first, rpt_rx_cap, rpt_rx_proxy_valid;
   logic [2:0] rpt_rx_node, rpt_rx_proxy, evt_node, lookup_dst, bsync_node;
   logic [1:0] rpt_rx_ack, rpt_rep;
   logic node_join, node_leave, node_lost, map_rx_valid, map_rx_dist, rupd_rx_valid;
   logic rupd_rx_ack, qry_rx_valid, rsq_rx_valid, topo_change, tbl_ld_valid;
   logic [3:0] map_rx_algo, map_algo;
   logic [15:0] map_rx_interval;
   logic [5:0] tbl_ld_idx;
   logic [7:0] tbl_ld_hop, next_hop, map_seq, rupd_seq, rupd_ack, rupd_relay;
   logic [7:0] bsync_diff, rsr_seq, qrep_fields, rk, v, h, f;
   logic map_dist, rupd_tx, rupd_full, rupd_tables, route_calc, bsync_tx, rsr_tx;
   logic rsq_tx, qrep_tx, rpt_tx, rpt_cap, resign;
   logic [47:0] q[$];
   logic [8:0] ms [5] = '{9'h0fd, 9'h0fe, 9'h101, 9'h17d, 9'h07e};
   int fail_count = 0;
   int tests_run = 0;
   integer seed = 32'h9e22ee97;

   drt_top #(.MS_CYCLES(4)) DUT (.*);
   drt_peer peer (.*);

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task rst;
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   // one APB transfer; idle edge first so strobes never change twice at once
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e);
      @(posedge pclk);
      q.push_back({8'd1, 7'h0, e});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, e);
   endtask
   task topo;
      topo_change <= 1'b1;
      @(posedge pclk);
      topo_change <= 1'b0;
   endtask
   task ck(input logic [47:0] got);
      tests_run++;
      if (q.size() == 0 || q[0] !== got) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, q[0]);
      end
      if (q.size() != 0) void'(q.pop_front());
   endtask
   // a note still waiting means a result never came
   task drained;
      tests_run++;
      if (q.size() != 0) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, 48'h0, q[0]);
      end
      q.delete();
   endtask
   task stop_test;
      if (q.size() != 0) fail_count++;
      if (fail_count == 0 && tests_run != 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // monitor: values seen at an edge, in a fixed order per cycle
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) ck({8'd1, 7'h0, pslverr, pwrite ? 32'h0 : prdata});
      if (route_calc === 1'b1) ck({8'd3, 40'h0});
      if (bsync_tx === 1'b1) ck({8'd8, 29'h0, bsync_node, bsync_diff});
      rk = q.size() != 0 ? q[0][47:40] : 8'd4;
      if (rupd_tx === 1'b1) ck({rk, 6'h0, rupd_tables, rupd_full & (rk != 8'd4),
         rk == 8'd7 ? rupd_relay : 8'h0, rk == 8'd7 ? rupd_ack : 8'h0,
         map_seq, rupd_seq});
      if (rsr_tx === 1'b1) ck({8'd5, 40'h0});
      if (rsq_tx === 1'b1) ck({8'd6, 40'h0});
      if (qrep_tx === 1'b1) ck({8'd9, 32'h0, qrep_fields});
      if (rpt_tx === 1'b1) ck({8'd10, 37'h0, rpt_cap, rpt_rep});
      if (resign === 1'b1) ck({8'd11, 40'h0});
   end

   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      stop_test();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, node_join, node_leave, node_lost, evt_node,
         topo_change, tbl_ld_valid, tbl_ld_idx, tbl_ld_hop, lookup_dst} = '0;
      presetn = 1'b0;
      rst();
      rd(`DRT_A_CTRL, 33'h0);
      rd(`DRT_A_PER, 33'h3e8);
      rd(`DRT_A_DLN, 33'h32);
      apb(1'b1, 8'h20, 32'h5, {1'b1, 32'h0});
      rd(8'h20, {1'b1, 32'h0});
      wr(`DRT_A_STAT, 32'hffff_ffff);
      rd(`DRT_A_STAT, 33'h2_0000);
      wr(`DRT_A_DLN, 32'h0);
      rd(`DRT_A_DLN, 33'h1);
      wr(`DRT_A_CTRL, 32'h1);
      wr(`DRT_A_DLN, 32'h2);
      // first report of a new node admitted by proxy, ack asked
      v = 8'($random(seed)) | 8'h01;
      q.push_back({8'd3, 40'h0});
      q.push_back({8'd8, 29'h0, 3'd3, v});
      q.push_back({8'd7, 7'h0, 1'b1, 8'h04, 8'h08, 8'h01, 8'h01});
      peer.report(3'd3, 8'h21, 2'b10, 1'b1, v, 1'b1);
      repeat (20) @(posedge pclk);
      drained();
      wr(`DRT_A_TIDX, 32'h18);
      rd(`DRT_A_VIS, {17'h0, 8'h21, v});
      h = 8'($random(seed));
      lookup_dst <= h[2:0];
      tbl_ld_valid <= 1'b1;
      tbl_ld_idx <= {3'd0, h[2:0]};
      tbl_ld_hop <= h;
      @(posedge pclk);
      tbl_ld_valid <= 1'b0;
      wr(`DRT_A_TIDX, {29'h0, h[2:0]});
      rd(`DRT_A_TDAT, {25'h0, h});
      // own slot is zero, so the lookup port reads the row just loaded
      @(posedge pclk);
      q.push_back({8'd13, 32'h0, h});
      ck({8'd13, 32'h0, next_hop});
      // join and loss back to back share one update, new tables flagged
      q.push_back({8'd3, 40'h0});
      q.push_back({8'd3, 40'h0});
      q.push_back({8'd4, 6'h0, 1'b1, 17'h0, 8'h02, 8'h02});
      evt_node <= 3'd5;
      node_join <= 1'b1;
      @(posedge pclk);
      node_join <= 1'b0;
      node_lost <= 1'b1;
      @(posedge pclk);
      node_lost <= 1'b0;
      repeat (20) @(posedge pclk);
      drained();
      q.push_back({8'd5, 40'h0});
      peer.resend();
      wr(`DRT_A_PER, 32'h0);
      // period reads back raw; the clamp acts only in the timer
      rd(`DRT_A_PER, 33'h0);
      wr(`DRT_A_PER, 32'hffff);
      rd(`DRT_A_PER, 33'hffff);
      wr(`DRT_A_PER, 32'h1f4);
      q.push_back({8'd12, 7'h0, 1'b1, 16'h0, 8'h03, 8'h03});
      repeat (2400) @(posedge pclk);
      drained();
      // distributed while every admitted node is capable, central once one is not
      wr(`DRT_A_CTRL, 32'h5);
      rd(`DRT_A_STAT, 33'h3_0003);
      node_join <= 1'b1;
      @(posedge pclk);
      node_join <= 1'b0;
      rd(`DRT_A_STAT, 33'h2_0003);
      // node role with own capability; wrap and boundary of plan sequence
      rst();
      wr(`DRT_A_CTRL, 32'h8);
      peer.upd(8'hfe, 1'b0);
      for (int i = 0; i < 5; i++) begin
         if (ms[i][8]) q.push_back({8'd6, 40'h0});
         peer.map(ms[i][7:0]);
      end
      f = 8'($random(seed));
      q.push_back({8'd9, 32'h0, f});
      peer.query(f);
      // slow ack inside the retry spacing stops repeats
      q.push_back({8'd10, 37'h0, 1'b1, 2'd1});
      topo();
      repeat (300) @(posedge pclk);
      peer.upd(8'h02, 1'b1);
      repeat (500) @(posedge pclk);
      drained();
      q.push_back({8'd14, 35'h0, 1'b0, 4'h1});
      ck({8'd14, 35'h0, map_dist, map_algo});
      for (int i = 1; i < 4; i++) q.push_back({8'd10, 37'h0, 1'b1, i[1:0]});
      q.push_back({8'd11, 40'h0});
      topo();
      repeat (1300) @(posedge pclk);
      stop_test();
   end
endmodule
`default_nettype wire
